// file: design/pih_pkg.sv
package pih_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned UNIT_W = 6;
  localparam int unsigned FUNC_W = 16;
  localparam int unsigned CLK_NS = 10;
  // mainframe memory cycle and phase pulses
  localparam int unsigned CYCLE_NS = 1750;
  localparam int unsigned CYCLE_CLKS = CYCLE_NS / CLK_NS;
  localparam int unsigned PHASES = 8;
  localparam int unsigned PHASE_CLKS = CYCLE_CLKS / PHASES;
  localparam logic [7:0] PH_CNT_MAX = 8'(PHASE_CLKS - 1);
  localparam logic [2:0] PH_T2 = 3'h1;
  localparam logic [2:0] PH_T8 = 3'h7;
  // instruction word fields
  localparam int unsigned IND_BIT = 5;
  localparam int unsigned MAP_BIT = 6;
  localparam int unsigned WAIT_BIT = 9;
  localparam int unsigned UNIT_LSB = 10;
  localparam int unsigned ADDR_W = 14;
  localparam logic [5:0] UNIT_ID_DEF = 6'h05;
  typedef enum logic [1:0]
  {
    OP_NONE = 2'h0,
    OP_TEST = 2'h1,
    OP_OUT  = 2'h2
  } pih_op_e;
endpackage

// file: design/pih_if.sv
`timescale 1ns/100ps
interface pih_if;
  import pih_pkg::*;
  logic                t_pulse;
  pih_op_e             op;
  logic                wait_flag;
  logic [UNIT_W-1:0]   unit_sel;
  logic                instr_strobe;
  logic                host_word_valid;
  logic [WORD_W-1:0]   io_bus;
  logic                sync_ack;
  logic                test_true;
  logic                word_taken;
  modport host
  (
    output t_pulse, op, wait_flag, unit_sel, instr_strobe,
    output host_word_valid, io_bus,
    input  sync_ack, test_true, word_taken
  );
  modport unit
  (
    input  t_pulse, op, wait_flag, unit_sel, instr_strobe,
    input  host_word_valid, io_bus,
    output sync_ack, test_true, word_taken
  );
endinterface

// file: design/pih_unit.sv
`timescale 1ns/100ps
// Functional notes
// (R1) selected test op: set test flop, ack sync
// (R2) host holds until sync acknowledge returns
// (R3) host word valid with second word
// (R4) compare function bits with own conditions
// (R5) raise word taken after test settles
// (R6) host skips on test true
// (R7) word valid drop clears true and taken
// (R8) done flop reset while word invalid
// (R9) host holds enables until next instruction; the host here returns op to OP_NONE in S_END
// (R10) immediate test op takes three cycles
// (R11) wait flag bit 9, unit bits 10-15
// (R12) wait mode withholds ack until ready
// (R13) skip mode: host skips when ready
// (R14) no interrupts during wait stall
// (R15) acc and mem out word sources
// (R16) output ops three cycles minimum
// (R17) mem op bit 5 indirect, bit 9 wait
// (R18) fourteen address bits, page extend
// (R19) indirect chains end in data word
// (R20) skip mode loops with jump op
// (R21) test op always skip, always ready
// (R22) ready output unit: true with ack
// (R23) load output register with word taken
// (R24) reset clears all handshake flops
module pih_unit
  import pih_pkg::*;
#(
  parameter logic [UNIT_W-1:0] UNIT_ID = UNIT_ID_DEF
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  pih_if.unit                    bus,
  input  wire logic [FUNC_W-1:0] cond_in,
  input  wire logic              buf_ready,
  output logic [WORD_W-1:0]      out_data,
  output logic                   out_load_pulse
);
  logic selected;
  logic tt_q;
  logic sync_q;
  logic done_q;
  logic [FUNC_W-1:0] cond_s1_q;
  logic [FUNC_W-1:0] cond_q;
  logic rdy_s1_q;
  logic rdy_q;
  logic stb_q;

  function automatic logic test_hit(input logic [FUNC_W-1:0] f,
                                    input logic [FUNC_W-1:0] c);
    test_hit = |(f & c);
  endfunction

  assign selected = (bus.unit_sel == UNIT_ID);

  // external conditions are asynchronous
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cond_s1_q <= '0;
      cond_q    <= '0;
      rdy_s1_q  <= 1'b0;
      rdy_q     <= 1'b0;
    end
    else
    begin
      cond_s1_q <= cond_in;
      cond_q    <= cond_s1_q;
      rdy_s1_q  <= buf_ready;
      rdy_q     <= rdy_s1_q;
    end
  end

  // strobe-phase handshake: sync acknowledge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sync_q <= 1'b0; // R24
    else if (!bus.instr_strobe || !selected)
      sync_q <= 1'b0;
    else if (bus.t_pulse && !sync_q)
    begin
      if (bus.op == OP_TEST)
        sync_q <= 1'b1; // R1 R21
      else if (bus.op == OP_OUT && (rdy_q || !bus.wait_flag))
        sync_q <= 1'b1; // R12 R22
    end
  end

  // test result / buffer-ready indication
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tt_q <= 1'b0; // R24
    else if (bus.op == OP_TEST)
    begin
      if (!bus.host_word_valid)
        tt_q <= 1'b0; // R7
      else if (selected && !done_q)
        tt_q <= test_hit(bus.io_bus, cond_q); // R4
    end
    else if (bus.op == OP_OUT)
    begin
      if (bus.instr_strobe && selected && bus.t_pulse && !sync_q)
        tt_q <= rdy_q; // R22
      else if (!bus.instr_strobe && !bus.host_word_valid)
        tt_q <= 1'b0;
    end
    else
      tt_q <= 1'b0;
  end

  // done flop: word taken
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      done_q <= 1'b0; // R24
    else if (!bus.host_word_valid)
      done_q <= 1'b0; // R8 R7
    else if (selected && bus.op != OP_NONE && bus.t_pulse && !done_q)
      done_q <= 1'b1; // R8 R5
  end

  // output register load
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_data <= '0;
      stb_q    <= 1'b0;
    end
    else
    begin
      stb_q <= 1'b0;
      if (bus.op == OP_OUT && bus.host_word_valid && selected
          && bus.t_pulse && !done_q)
      begin
        out_data <= bus.io_bus; // R23
        stb_q    <= 1'b1;
      end
    end
  end

  assign out_load_pulse = stb_q;
  assign bus.sync_ack   = sync_q;
  assign bus.test_true  = tt_q;
  assign bus.word_taken = done_q;
endmodule

// file: design/pih_host.sv
`timescale 1ns/100ps
module pih_host
  import pih_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  pih_if.host                    bus,
  input  wire logic              go,
  input  wire pih_op_e           go_op,
  input  wire logic [WORD_W-1:0] instr_word,
  input  wire logic [WORD_W-1:0] data_word,
  output logic                   busy,
  output logic                   done,
  output logic                   skip
);
  typedef enum logic [2:0]
  {
    S_IDLE = 3'b000,
    S_HOLD = 3'b001,
    S_DATA = 3'b011,
    S_WAIT = 3'b010,
    S_END  = 3'b110
  } pih_st_e;

  pih_st_e st_q;
  logic [7:0] ph_cnt_q;
  logic [2:0] ph_q;
  logic tp_q;
  pih_op_e op_q;
  logic wait_q, strobe_q, hwv_q;
  logic [UNIT_W-1:0] unit_q;
  logic [WORD_W-1:0] word_q;
  logic skip_q, done_q, busy_q;

  // T-phase pulses, two per memory cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ph_cnt_q <= '0;
      ph_q     <= '0;
      tp_q     <= 1'b0;
    end
    else
    begin
      tp_q <= 1'b0;
      if (ph_cnt_q == PH_CNT_MAX)
      begin
        ph_cnt_q <= '0;
        ph_q     <= ph_q + 3'h1;
        tp_q     <= (ph_q == PH_T2) || (ph_q == PH_T8);
      end
      else
        ph_cnt_q <= ph_cnt_q + 8'h01;
    end
  end

  // instruction sequencer; unit replies share this clock, read directly
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q     <= S_IDLE;
      op_q     <= OP_NONE;
      wait_q   <= 1'b0;
      unit_q   <= '0;
      word_q   <= '0;
      strobe_q <= 1'b0;
      hwv_q    <= 1'b0;
      skip_q   <= 1'b0;
      done_q   <= 1'b0;
      busy_q   <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        S_IDLE:
          if (go)
          begin
            op_q     <= go_op; // R9 R15
            wait_q   <= (go_op == OP_OUT) && instr_word[WAIT_BIT]; // R11 R21
            unit_q   <= instr_word[UNIT_LSB +: UNIT_W]; // R11
            word_q   <= data_word; // R17 R18 R19
            strobe_q <= 1'b1; // R2
            busy_q   <= 1'b1;
            st_q     <= S_HOLD;
          end
        S_HOLD:
          if (bus.sync_ack)
          begin
            strobe_q <= 1'b0; // R2 R14
            skip_q   <= bus.test_true;
            if (op_q == OP_TEST || bus.test_true)
            begin
              hwv_q <= 1'b1; // R3
              st_q  <= S_DATA;
            end
            else
              st_q <= S_END; // R13 R20
          end
        S_DATA:
          if (bus.word_taken)
          begin
            if (op_q == OP_TEST)
              skip_q <= bus.test_true; // R6
            hwv_q <= 1'b0; // R7
            st_q  <= S_WAIT;
          end
        S_WAIT:
          if (!bus.word_taken && !bus.sync_ack)
            st_q <= S_END;
        S_END:
        begin
          done_q <= 1'b1; // R10 R16
          op_q   <= OP_NONE;
          busy_q <= 1'b0;
          st_q   <= S_IDLE;
        end
        default:
        begin
          st_q   <= S_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  assign bus.t_pulse         = tp_q;
  assign bus.op              = op_q;
  assign bus.wait_flag       = wait_q;
  assign bus.unit_sel        = unit_q;
  assign bus.instr_strobe    = strobe_q;
  assign bus.host_word_valid = hwv_q;
  assign bus.io_bus          = word_q;
  assign busy = busy_q;
  assign done = done_q;
  assign skip = skip_q;
endmodule

// file: tb/pih_monitor.sv
`timescale 1ns/100ps
module pih_monitor
  import pih_pkg::*;
#(
  parameter logic [UNIT_W-1:0] UNIT_ID = UNIT_ID_DEF
)
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              t_pulse,
  input wire pih_op_e           op,
  input wire logic              wait_flag,
  input wire logic [UNIT_W-1:0] unit_sel,
  input wire logic              instr_strobe,
  input wire logic              host_word_valid,
  input wire logic              sync_ack,
  input wire logic              test_true,
  input wire logic              word_taken
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence test_req;
    op == OP_TEST && instr_strobe && unit_sel == UNIT_ID && t_pulse;
  endsequence
  sequence data_req;
    op != OP_NONE && host_word_valid && unit_sel == UNIT_ID && t_pulse;
  endsequence
  ack_on_pulse_a: assert property (test_req |=> sync_ack)
    else $error("sync ack missing after pulse");
  ack_timing_a: assert property
    ($rose(sync_ack) |-> $past(t_pulse) && $past(instr_strobe))
    else $error("sync ack rose without pulse and strobe");
  ack_select_a: assert property
    (unit_sel != UNIT_ID |-> !sync_ack && !word_taken)
    else $error("unselected unit answered");
  ack_hold_a: assert property (sync_ack && instr_strobe |=> sync_ack)
    else $error("sync ack dropped under strobe");
  wait_ready_a: assert property
    (op == OP_OUT && wait_flag && sync_ack |-> test_true)
    else $error("wait mode ack while not ready");
  true_with_ack_a: assert property
    (op == OP_OUT && $rose(test_true) |-> $rose(sync_ack))
    else $error("test true apart from sync ack");
  taken_on_valid_a: assert property (data_req |=> word_taken)
    else $error("word taken missing after pulse");
  taken_release_a: assert property
    (!host_word_valid && !instr_strobe |=> !word_taken && !test_true)
    else $error("flags stand after valid drop");
endmodule

// file: tb/test_peripheral_io_handshake.sv
`timescale 1ns/100ps
module test_peripheral_io_handshake;
  import pih_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              go = 1'b0;
  pih_op_e           go_op = OP_NONE;
  logic [WORD_W-1:0] instr_word = 16'h0000;
  logic [WORD_W-1:0] data_word = 16'h0000;
  logic [FUNC_W-1:0] cond_in = 16'h0010;
  logic              buf_ready = 1'b1;
  logic [WORD_W-1:0] out_data;
  logic              out_load_pulse;
  logic              busy;
  logic              done;
  logic              skip;
  logic              got;
  int                fails = 0;
  int                tests_run = 0;
  int                cycles = 0;
  int                loads = 0;

  pih_if pih_if_i ();
  pih_host pih_host_i (.clk(clk), .rst_n(rst_n), .bus(pih_if_i),
    .go(go), .go_op(go_op), .instr_word(instr_word),
    .data_word(data_word), .busy(busy), .done(done), .skip(skip));
  pih_unit pih_unit_i (.clk(clk), .rst_n(rst_n), .bus(pih_if_i),
    .cond_in(cond_in), .buf_ready(buf_ready), .out_data(out_data),
    .out_load_pulse(out_load_pulse));
  pih_monitor pih_monitor_i (.clk(clk), .rst_n(rst_n),
    .t_pulse(pih_if_i.t_pulse), .op(pih_if_i.op),
    .wait_flag(pih_if_i.wait_flag), .unit_sel(pih_if_i.unit_sel),
    .instr_strobe(pih_if_i.instr_strobe),
    .host_word_valid(pih_if_i.host_word_valid),
    .sync_ack(pih_if_i.sync_ack), .test_true(pih_if_i.test_true),
    .word_taken(pih_if_i.word_taken));

  always #5 clk = ~clk;

  task automatic conclude();
    $display("checks %0d failures %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      conclude();
    end
  end

  // count output register strobes
  always @(posedge clk)
  begin
    if (out_load_pulse === 1'b1)
      loads <= loads + 1;
  end

  task automatic check(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wait_done(input int lim);
    got = 1'b0;
    repeat (lim)
      if (!got)
      begin
        @(posedge clk);
        #1;
        got = (done === 1'b1);
      end
  endtask

  // one go pulse, then bounded wait for done
  task automatic run_op(input pih_op_e o, input logic [5:0] u,
    input logic w, input logic [15:0] d, input logic rdy, input int lim);
    @(posedge clk);
    buf_ready <= rdy;
    // let the ready level pass the unit's synchroniser first
    repeat (3) @(posedge clk);
    go <= 1'b1;
    go_op <= o;
    instr_word <= {u, w, 9'h000};
    data_word <= d;
    @(posedge clk);
    go <= 1'b0;
    wait_done(lim);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    run_op(OP_TEST, UNIT_ID_DEF, 1'b0, 16'h0030, 1'b0, 1000);
    check(16'(got), 16'h0001);
    check(16'(skip), 16'h0001);
    run_op(OP_TEST, UNIT_ID_DEF, 1'b0, 16'h0001, 1'b1, 1000);
    check(16'(skip), 16'h0000);
    run_op(OP_OUT, UNIT_ID_DEF, 1'b0, 16'hA5C3, 1'b1, 1000);
    check(16'(skip), 16'h0001);
    check(out_data, 16'hA5C3);
    check(16'(loads), 16'h0001);
    run_op(OP_OUT, UNIT_ID_DEF, 1'b0, 16'h5A3C, 1'b0, 1000);
    check(16'(skip), 16'h0000);
    check(out_data, 16'hA5C3);
    check(16'(loads), 16'h0001);
    run_op(OP_OUT, UNIT_ID_DEF, 1'b1, 16'h0F0F, 1'b0, 600);
    check(16'(got), 16'h0000);
    @(posedge clk);
    buf_ready <= 1'b1;
    wait_done(1000);
    check(16'(skip), 16'h0001);
    check(out_data, 16'h0F0F);
    check(16'(loads), 16'h0002);
    run_op(OP_TEST, 6'h3F, 1'b0, 16'h0010, 1'b1, 600);
    check(16'(busy), 16'h0001);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check(16'({pih_if_i.sync_ack, pih_if_i.test_true,
      pih_if_i.word_taken}), 16'h0000);
    check(16'(busy), 16'h0000);
    conclude();
  end
endmodule
